// *** rtl/pgee_pkg.sv ***
package pgee_pkg;
  localparam int PGEE_ADDR_W = 15;
  localparam int PGEE_DATA_W = 8;
  localparam int PGEE_PAGE_BYTES = 64;
  localparam int PGEE_PG_LSB = 6;
  localparam int PGEE_CLK_NS = 10;
  // Strobe timing in ns; load window in us, power-on wait in ms
  localparam int PGEE_STROBE_LOW_NS = 100;
  localparam int PGEE_STROBE_HIGH_NS = 50;
  localparam int PGEE_SETUP_NS = 50;
  localparam int PGEE_OE_DELAY_NS = 150;
  localparam int PGEE_OE_HIGH_NS = 150;
  localparam int PGEE_LOAD_WIN_US = 150;
  localparam int PGEE_POWERON_MS = 5;
  // Cycle counts; least times round up, window and power-on wait round down
  localparam int PGEE_LOW_CYC = (PGEE_STROBE_LOW_NS + PGEE_CLK_NS - 1) / PGEE_CLK_NS;
  localparam int PGEE_HIGH_CYC = (PGEE_STROBE_HIGH_NS + PGEE_CLK_NS - 1) / PGEE_CLK_NS;
  localparam int PGEE_SETUP_CYC = (PGEE_SETUP_NS + PGEE_CLK_NS - 1) / PGEE_CLK_NS;
  localparam int PGEE_OE_CYC = (PGEE_OE_DELAY_NS + PGEE_CLK_NS - 1) / PGEE_CLK_NS;
  localparam int PGEE_OEH_CYC = (PGEE_OE_HIGH_NS + PGEE_CLK_NS - 1) / PGEE_CLK_NS;
  localparam int PGEE_WIN_CYC = PGEE_LOAD_WIN_US * 1000 / PGEE_CLK_NS;
  localparam int PGEE_PON_CYC = PGEE_POWERON_MS * 1000000 / PGEE_CLK_NS;
  localparam int PGEE_CNT_W = 20;
  // Protection command sequence
  localparam logic [14:0] PGEE_CMD_ADDR1 = 15'h5555;
  localparam logic [14:0] PGEE_CMD_ADDR2 = 15'h2AAA;
  localparam logic [7:0] PGEE_CMD_DATA1 = 8'hAA;
  localparam logic [7:0] PGEE_CMD_DATA2 = 8'h55;
  localparam logic [7:0] PGEE_CMD_PROT = 8'hA0;
  localparam logic [7:0] PGEE_CMD_UNPROT = 8'h20;
  localparam logic [14:0] PGEE_ID_BASE = 15'h7FC0;
  localparam int PGEE_POLL_BIT = 7;
  localparam int PGEE_TOGGLE_BIT = 6;
  // Host commands
  localparam logic [1:0] PGEE_OP_READ = 2'h0;
  localparam logic [1:0] PGEE_OP_LOAD = 2'h1;
  localparam logic [1:0] PGEE_OP_PROT_ON = 2'h2;
  localparam logic [1:0] PGEE_OP_PROT_OFF = 2'h3;
  typedef enum logic [2:0] {
    PGEE_IDLE = 3'b000,
    PGEE_SETUP = 3'b001,
    PGEE_WLOW = 3'b010,
    PGEE_WHIGH = 3'b011,
    PGEE_RD = 3'b100,
    PGEE_RGAP = 3'b101,
    PGEE_POLL = 3'b110,
    PGEE_PON = 3'b111
  } pgee_state_t;
endpackage

// *** rtl/pgee_host.sv ***
// Function
// - Write pulses write strobe low while chip select low, gate high.
// - Next strobe fall within 150 us of previous strobe rise.
// - Page bits held constant at every strobe fall of a load.
// - True data after completion; new access only after detection.
// - Three command writes switch protection on.
// - With protection on, every write is prefixed by the sequence; code prefixes only a load's first write, and only if cmd_protected.
// - Command writes obey page-load strobe timing and window.
// - High voltage on line nine selects 64-byte id area.
`timescale 1ns/1ps
`default_nettype none
module pgee_host
  import pgee_pkg::*;
#(
  parameter int WIN_CYC = PGEE_WIN_CYC,
  parameter int PON_CYC = PGEE_PON_CYC
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic [PGEE_ADDR_W-1:0] cmd_addr,
  input wire logic [PGEE_DATA_W-1:0] cmd_data,
  input wire logic cmd_last,
  input wire logic cmd_id_area,
  input wire logic cmd_protected,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [PGEE_DATA_W-1:0] rsp_data,
  output logic write_done,
  output logic chip_select_n,
  output logic output_gate_n,
  output logic write_strobe_n,
  output logic id_area_select_line,
  output logic [PGEE_ADDR_W-1:0] address_lines,
  output logic [PGEE_DATA_W-1:0] data_lines_out,
  output logic data_lines_oe,
  input wire logic [PGEE_DATA_W-1:0] data_lines_in
);
////////////////////////////////////////////////////////////////////////
  logic rst_sync1_reg;
  logic rst_n_reg;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync1_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_n_reg <= rst_sync1_reg;
    end
  end
////////////////////////////////////////////////////////////////////////
  pgee_state_t state_reg, state_next;
  logic [PGEE_CNT_W-1:0] cnt_reg, cnt_next;
  logic [PGEE_CNT_W-1:0] win_reg, win_next;
  logic [1:0] seq_reg, seq_next;
  logic [1:0] op_reg, op_next;
  logic last_reg, last_next;
  logic in_load_reg, in_load_next;
  logic [PGEE_ADDR_W-PGEE_PG_LSB-1:0] page_reg, page_next;
  logic [PGEE_DATA_W-1:0] wdata_reg, wdata_next;
  logic [PGEE_ADDR_W-1:0] waddr_reg, waddr_next;
  logic [PGEE_DATA_W-1:0] prev_reg, prev_next;
  logic prev_ok_reg, prev_ok_next;
  logic cmd_ready_next, rsp_valid_next, write_done_next;
  logic [PGEE_DATA_W-1:0] rsp_data_next;
  logic cs_next, oe_next, we_next, id_next, doe_next;
  logic [PGEE_ADDR_W-1:0] addr_next;
  logic [PGEE_DATA_W-1:0] dout_next;

  // Address and data of the i-th protection command step
  function automatic logic [PGEE_ADDR_W-1:0] seq_addr(input logic [1:0] s);
    seq_addr = (s == 2'h1) ? PGEE_CMD_ADDR2 : PGEE_CMD_ADDR1;
  endfunction
  function automatic logic [PGEE_DATA_W-1:0] seq_data(input logic [1:0] s,
      input logic [1:0] op);
    unique case (s)
      2'h0: seq_data = PGEE_CMD_DATA1;
      2'h1: seq_data = PGEE_CMD_DATA2;
      default: seq_data = (op == PGEE_OP_PROT_OFF) ? PGEE_CMD_UNPROT
                                                    : PGEE_CMD_PROT;
    endcase
  endfunction

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    win_next = win_reg;
    seq_next = seq_reg;
    op_next = op_reg;
    last_next = last_reg;
    in_load_next = in_load_reg;
    page_next = page_reg;
    wdata_next = wdata_reg;
    waddr_next = waddr_reg;
    prev_next = prev_reg;
    prev_ok_next = prev_ok_reg;
    cmd_ready_next = 1'b0;
    rsp_valid_next = 1'b0;
    rsp_data_next = rsp_data;
    write_done_next = 1'b0;
    cs_next = chip_select_n;
    oe_next = output_gate_n;
    we_next = write_strobe_n;
    id_next = id_area_select_line;
    doe_next = data_lines_oe;
    addr_next = address_lines;
    dout_next = data_lines_out;
    if (in_load_reg && win_reg != '0) begin
      win_next = win_reg - 1'b1;
    end
    unique case (state_reg)
      PGEE_PON: begin
        if (cnt_reg == '0) begin
          state_next = PGEE_IDLE;
          cmd_ready_next = 1'b1;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      PGEE_IDLE: begin
        cmd_ready_next = 1'b1;
        if (in_load_reg && (win_reg == '0 || !(cmd_valid && cmd_ready))) begin
          // Stop before the window runs out, leaving one setup time plus one pulse of margin
          if (win_reg <= PGEE_CNT_W'(PGEE_SETUP_CYC + PGEE_LOW_CYC)) begin
            in_load_next = 1'b0;
            state_next = PGEE_POLL;
            cmd_ready_next = 1'b0;
            cnt_next = '0;
            prev_ok_next = 1'b0;
          end
        end
        if (cmd_valid && cmd_ready) begin
          cmd_ready_next = 1'b0;
          op_next = cmd_op;
          last_next = cmd_last;
          id_next = cmd_id_area;
          cnt_next = '0;
          if (cmd_op == PGEE_OP_READ) begin
            addr_next = cmd_addr;
            cs_next = 1'b0;
            oe_next = 1'b0;
            state_next = PGEE_RD;
          end else begin
            waddr_next = cmd_addr;
            wdata_next = cmd_data;
            // Prefix the command sequence at load start when protected
            seq_next = (cmd_op != PGEE_OP_LOAD ||
                        (cmd_protected && !in_load_reg)) ? 2'h0 : 2'h3;
            if (cmd_op == PGEE_OP_LOAD && in_load_reg) begin
              page_next = page_reg;
            end else begin
              page_next = cmd_addr[PGEE_ADDR_W-1:PGEE_PG_LSB];
            end
            state_next = PGEE_SETUP;
          end
        end
      end
      PGEE_SETUP: begin
        oe_next = 1'b1;
        cs_next = 1'b0;
        doe_next = 1'b1;
        if (seq_reg != 2'h3) begin
          addr_next = seq_addr(seq_reg);
          dout_next = seq_data(seq_reg, op_reg);
        end else begin
          // Page bits frozen for the whole load
          addr_next = {page_reg, waddr_reg[PGEE_PG_LSB-1:0]};
          dout_next = wdata_reg;
        end
        if (cnt_reg >= PGEE_CNT_W'(PGEE_SETUP_CYC)) begin
          we_next = 1'b0;
          cnt_next = '0;
          state_next = PGEE_WLOW;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      PGEE_WLOW: begin
        // Pulse far longer than any glitch filter
        if (cnt_reg >= PGEE_CNT_W'(PGEE_LOW_CYC)) begin
          we_next = 1'b1;
          cnt_next = '0;
          in_load_next = 1'b1;
          win_next = PGEE_CNT_W'(WIN_CYC);
          state_next = PGEE_WHIGH;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      PGEE_WHIGH: begin
        if (cnt_reg >= PGEE_CNT_W'(PGEE_HIGH_CYC)) begin
          cnt_next = '0;
          doe_next = 1'b0;
          cs_next = 1'b1;
          if (seq_reg == 2'h2 && op_reg != PGEE_OP_LOAD) begin
            seq_next = 2'h3; // programs the flag alone
            state_next = PGEE_IDLE;
            last_next = 1'b1;
          end else if (seq_reg != 2'h3) begin
            seq_next = seq_reg + 1'b1;
            state_next = PGEE_SETUP;
          end else begin
            state_next = PGEE_IDLE;
          end
          if (state_next == PGEE_IDLE && last_next) begin
            win_next = '0; // end of load: go poll
          end
          cmd_ready_next = 1'b0;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      PGEE_RD: begin
        if (cnt_reg >= PGEE_CNT_W'(PGEE_OE_CYC)) begin
          rsp_data_next = data_lines_in;
          rsp_valid_next = 1'b1;
          oe_next = 1'b1;
          cs_next = 1'b1;
          cnt_next = '0;
          state_next = PGEE_RGAP;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      PGEE_RGAP: begin
        if (cnt_reg >= PGEE_CNT_W'(PGEE_OEH_CYC)) begin
          state_next = PGEE_IDLE;
          cmd_ready_next = 1'b1;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      PGEE_POLL: begin
        // Read the last byte written until bits six and seven both match the previous read
        addr_next = {page_reg, waddr_reg[PGEE_PG_LSB-1:0]};
        if (cnt_reg == '0) begin
          cs_next = 1'b0;
          oe_next = 1'b0;
          cnt_next = cnt_reg + 1'b1;
        end else if (cnt_reg >= PGEE_CNT_W'(PGEE_OE_CYC)) begin
          cs_next = 1'b1;
          oe_next = 1'b1;
          prev_next = data_lines_in;
          prev_ok_next = 1'b1;
          if (prev_ok_reg &&
              prev_reg[PGEE_TOGGLE_BIT] == data_lines_in[PGEE_TOGGLE_BIT] &&
              prev_reg[PGEE_POLL_BIT] == data_lines_in[PGEE_POLL_BIT]) begin
            write_done_next = 1'b1;
            state_next = PGEE_RGAP;
            cnt_next = '0;
          end else begin
            cnt_next = PGEE_CNT_W'(PGEE_OE_CYC) - PGEE_CNT_W'(PGEE_OEH_CYC);
            state_next = PGEE_POLL;
          end
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
        if (state_next == PGEE_POLL && cnt_reg >= PGEE_CNT_W'(PGEE_OE_CYC)
            && cnt_next[PGEE_CNT_W-1]) begin
          cnt_next = '0;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= PGEE_PON;
      cnt_reg <= PGEE_CNT_W'(PON_CYC);
      win_reg <= '0;
      seq_reg <= 2'h3;
      op_reg <= PGEE_OP_READ;
      last_reg <= 1'b0;
      in_load_reg <= 1'b0;
      page_reg <= '0;
      wdata_reg <= '0;
      waddr_reg <= '0;
      prev_reg <= '0;
      prev_ok_reg <= 1'b0;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      write_done <= 1'b0;
      chip_select_n <= 1'b1;
      output_gate_n <= 1'b1;
      write_strobe_n <= 1'b1;
      id_area_select_line <= 1'b0;
      address_lines <= '0;
      data_lines_out <= '0;
      data_lines_oe <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      win_reg <= win_next;
      seq_reg <= seq_next;
      op_reg <= op_next;
      last_reg <= last_next;
      in_load_reg <= in_load_next;
      page_reg <= page_next;
      wdata_reg <= wdata_next;
      waddr_reg <= waddr_next;
      prev_reg <= prev_next;
      prev_ok_reg <= prev_ok_next;
      cmd_ready <= cmd_ready_next;
      rsp_valid <= rsp_valid_next;
      rsp_data <= rsp_data_next;
      write_done <= write_done_next;
      chip_select_n <= cs_next;
      output_gate_n <= oe_next;
      write_strobe_n <= we_next;
      id_area_select_line <= id_next;
      address_lines <= addr_next;
      data_lines_out <= dout_next;
      data_lines_oe <= doe_next;
    end
  end
endmodule
`default_nettype wire

// *** test/pgee_host_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module pgee_host_props
  import pgee_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic chip_select_n,
  input wire logic output_gate_n,
  input wire logic write_strobe_n,
  input wire logic [PGEE_ADDR_W-1:0] address_lines,
  input wire logic [PGEE_DATA_W-1:0] data_lines_out,
  input wire logic data_lines_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Low strobe run length; saturates so long pulses stay legal
  logic [3:0] low_run;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      low_run <= 4'h0;
    end else if (write_strobe_n) begin
      low_run <= 4'h0;
    end else if (low_run != 4'hF) begin
      low_run <= low_run + 4'h1;
    end
  end
  AST_RD_DRIVE: assert property (
    !output_gate_n |-> !chip_select_n && write_strobe_n && !data_lines_oe)
    else $error("read strobes wrong");
  AST_NO_FIGHT: assert property (
    data_lines_oe |-> output_gate_n) else $error("bus contention");
  AST_WR_FRAME: assert property (
    !write_strobe_n |-> output_gate_n && !chip_select_n && data_lines_oe)
    else $error("write frame wrong");
  AST_LATCH_STABLE: assert property (
    !write_strobe_n && $past(!write_strobe_n) |->
    $stable(address_lines) && $stable(data_lines_out))
    else $error("address or data moved in pulse");
  AST_DATA_SETUP: assert property (
    $fell(write_strobe_n) |-> $past(data_lines_oe, 5))
    else $error("data setup short");
  AST_PULSE_LOW: assert property (
    $rose(write_strobe_n) |-> low_run >= 4'(PGEE_LOW_CYC))
    else $error("write pulse short");
  AST_PULSE_HIGH: assert property (
    $rose(write_strobe_n) |-> write_strobe_n [*5])
    else $error("strobe high time short");
  AST_READY_IDLE: assert property (
    cmd_ready |-> chip_select_n && write_strobe_n && output_gate_n)
    else $error("ready while bus busy");
  AST_RSP_SRC: assert property (
    rsp_valid |-> $past(!output_gate_n && !chip_select_n))
    else $error("response without read");
endmodule
bind pgee_host pgee_host_props u_props (
  .clock(clock),
  .reset_n(reset_n),
  .cmd_ready(cmd_ready),
  .rsp_valid(rsp_valid),
  .chip_select_n(chip_select_n),
  .output_gate_n(output_gate_n),
  .write_strobe_n(write_strobe_n),
  .address_lines(address_lines),
  .data_lines_out(data_lines_out),
  .data_lines_oe(data_lines_oe)
);
`default_nettype wire

// *** test/pgee_dev.sv ***
`timescale 1ns/1ps
`default_nettype none
module pgee_dev
  import pgee_pkg::*;
#(
  parameter int WIN = 200,
  parameter int PROG = 300,
  parameter int PON = 10
) (
  input wire logic clock,
  input wire logic cs_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic hv,
  input wire logic [14:0] a,
  input wire logic [7:0] d,
  output logic [7:0] q,
  output logic busy
);
  logic [7:0] mem [int];
  logic [7:0] id [64];
  logic [7:0] pg [64];
  logic [63:0] ld = '0;
  logic [14:0] pa, la;
  logic [7:0] lv = 8'hFF;
  logic wq = 0, rq = 0, prot = 0, pid = 0, tg = 0, on = 0, off = 0;
  int win = 0, prg = 0, sq = 0, pon = PON;
  wire logic wr = !cs_n && !we_n && oe_n;
  wire logic rd = !cs_n && !oe_n && we_n;
  assign busy = prg != 0;
  initial begin
    q = 8'h00;
    foreach (id[i]) id[i] = 8'hFF;
  end
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    wq <= wr;
    rq <= rd;
    if (pon > 0) pon <= pon - 1;
    if (prg > 0) prg <= prg - 1;
    if (wr && !wq) la <= a;
    if (!wr && wq && pon == 0 && !busy) begin
      win <= WIN;
      if (sq < 3 && la == (sq == 1 ? PGEE_CMD_ADDR2 : PGEE_CMD_ADDR1) &&
          (sq == 0 ? d == PGEE_CMD_DATA1 : sq == 1 ? d == PGEE_CMD_DATA2 :
          (d == PGEE_CMD_PROT || d == PGEE_CMD_UNPROT))) begin
        sq <= sq + 1;
        on <= sq == 2 && d == PGEE_CMD_PROT;
        off <= sq == 2 && d == PGEE_CMD_UNPROT;
      end else begin
        if (sq < 3) sq <= 4;
        if (ld == 0) pa <= la;
        if (ld == 0) pid <= hv;
        pg[la[5:0]] <= d;
        ld[la[5:0]] <= 1'b1;
        lv <= d;
      end
    end else if (win > 0 && (win == 1 || rd)) begin
      win <= 0;
      if (!prot || sq == 3) begin
        for (int i = 0; i < 64; i++) begin
          if (ld[i] && pid) id[i] = pg[i];
          else if (ld[i]) mem[int'({pa[14:6], i[5:0]})] = pg[i];
        end
        prot <= on ? 1'b1 : off ? 1'b0 : prot;
        prg <= PROG;
      end
      ld <= '0;
      sq <= 0;
      on <= 0;
      off <= 0;
    end else if (win > 0) win <= win - 1;
    if (rd) begin
      if (!rq) tg <= !tg;
      if (busy) q <= {~lv[7], tg, lv[5:0]};
      else if (hv && a >= PGEE_ID_BASE) q <= id[a[5:0]];
      else q <= mem.exists(int'(a)) ? mem[int'(a)] : 8'hFF;
    end else q <= ~q;
  end
endmodule
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb
  import pgee_pkg::*;
;
  logic clock = 0, reset_n = 0, cmd_valid = 0, cmd_last = 0;
  logic cmd_id_area = 0, cmd_protected = 0;
  logic [1:0] cmd_op = '0;
  logic [14:0] cmd_addr = '0;
  logic [7:0] cmd_data = '0;
  wire logic cmd_ready, rsp_valid, write_done, cs_n, oe_n, we_n, hv, d_oe;
  wire logic busy;
  wire logic [14:0] adr;
  wire logic [7:0] rsp_data, d_out, d_in;
  int errors = 0, cmp_count = 0;
  always #5 clock = ~clock;
  pgee_host #(.WIN_CYC(200), .PON_CYC(10)) dut_u (
    .clock(clock), .reset_n(reset_n), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .cmd_last(cmd_last), .cmd_id_area(cmd_id_area),
    .cmd_protected(cmd_protected), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .write_done(write_done),
    .chip_select_n(cs_n), .output_gate_n(oe_n), .write_strobe_n(we_n),
    .id_area_select_line(hv), .address_lines(adr),
    .data_lines_out(d_out), .data_lines_oe(d_oe), .data_lines_in(d_in));
  pgee_dev dev_u (.clock(clock), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
    .hv(hv), .a(adr), .d(d_out), .q(d_in), .busy(busy));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(inout int n);
    @(posedge clock);
    #1;
    n++;
  endtask
  task automatic issue(input logic [1:0] op, input logic [14:0] ad,
      input logic [7:0] dt, input logic lst, input logic idf,
      input logic pr);
    int n;
    n = 0;
    cmd_op = op;
    cmd_addr = ad;
    cmd_data = dt;
    cmd_last = lst;
    cmd_id_area = idf;
    cmd_protected = pr;
    cmd_valid = 1;
    while (cmd_ready !== 1'b1 && n < 3000) tick(n);
    if (cmd_ready !== 1'b1) chk(8'h01, 8'h00);
    tick(n);
    cmd_valid = 0;
    // Let an edge pass so the next call does not re-raise valid at once
    tick(n);
  endtask
  task automatic rd(input logic [14:0] ad, input logic idf,
      input logic [7:0] exp);
    int n;
    n = 0;
    issue(PGEE_OP_READ, ad, 8'h00, 1'b0, idf, 1'b0);
    while (rsp_valid !== 1'b1 && n < 100) tick(n);
    if (rsp_valid !== 1'b1) chk(8'h01, 8'h00);
    chk(rsp_data, exp);
  endtask
  task automatic done();
    int n;
    n = 0;
    while (write_done !== 1'b1 && n < 5000) tick(n);
    chk({6'h00, busy, write_done}, 8'h01);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) tick(n);
    chk({5'h00, cs_n, oe_n, we_n}, 8'h07);
    chk({7'h00, n >= 10}, 8'h01);
  endtask
  task automatic t_read();
    rd(15'h1234, 1'b0, 8'hFF);
    rd(15'h7FFF, 1'b0, 8'hFF);
  endtask
  task automatic t_page();
    issue(PGEE_OP_LOAD, 15'h0105, 8'h11, 1'b0, 1'b0, 1'b0);
    issue(PGEE_OP_LOAD, 15'h0102, 8'h22, 1'b0, 1'b0, 1'b0);
    issue(PGEE_OP_LOAD, 15'h0105, 8'h33, 1'b0, 1'b0, 1'b0);
    issue(PGEE_OP_LOAD, 15'h013F, 8'h44, 1'b1, 1'b0, 1'b0);
    done();
    rd(15'h0105, 1'b0, 8'h33);
    rd(15'h0102, 1'b0, 8'h22);
    rd(15'h013F, 1'b0, 8'h44);
    rd(15'h0103, 1'b0, 8'hFF);
  endtask
  task automatic t_window();
    issue(PGEE_OP_LOAD, 15'h2000, 8'h5A, 1'b0, 1'b0, 1'b0);
    done();
    rd(15'h2000, 1'b0, 8'h5A);
  endtask
  task automatic t_prot();
    issue(PGEE_OP_PROT_ON, 15'h0000, 8'h00, 1'b0, 1'b0, 1'b0);
    done();
    issue(PGEE_OP_LOAD, 15'h3000, 8'hC3, 1'b1, 1'b0, 1'b0);
    done();
    rd(15'h3000, 1'b0, 8'hFF);
    issue(PGEE_OP_LOAD, 15'h3000, 8'hC3, 1'b1, 1'b0, 1'b1);
    done();
    rd(15'h3000, 1'b0, 8'hC3);
    issue(PGEE_OP_PROT_OFF, 15'h0000, 8'h00, 1'b0, 1'b0, 1'b0);
    done();
    issue(PGEE_OP_LOAD, 15'h3001, 8'h7E, 1'b1, 1'b0, 1'b0);
    done();
    rd(15'h3001, 1'b0, 8'h7E);
  endtask
  task automatic t_id();
    issue(PGEE_OP_LOAD, 15'h7FC5, 8'hA5, 1'b1, 1'b1, 1'b0);
    done();
    rd(15'h7FC5, 1'b1, 8'hA5);
    rd(15'h7FC5, 1'b0, 8'hFF);
  endtask
  task automatic stop_test();
    if (errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    if (busy && !we_n) chk(8'h01, 8'h00);
  end
  initial begin
    repeat (3) @(posedge clock);
    #1;
    reset_n = 1;
    t_reset();
    t_read();
    t_page();
    t_window();
    t_prot();
    t_id();
    stop_test();
  end
  initial begin
    #400000;
    errors++;
    stop_test();
  end
endmodule
`default_nettype wire
